// ===== bench/csc_crc_checker.sv
// assertions on the crc unit ports: frame flags, serial output, mismatch flag.
// assumes a bind to csc_crc_top with the check enable left on.
`timescale 1ns/1ps
module csc_crc_checker (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic word_ce,
	input wire logic [7:0] frame_index,
	input wire logic status_in,
	input wire logic status_out,
	input wire logic crc_out_en,
	input wire logic last_frame_flag,
	input wire logic block_start_flag,
	input wire logic crc_err
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// frames that carry the check byte
	wire in_win = frame_index >= 8'hB8 && frame_index <= 8'hBF;
	wire at_start = word_ce && frame_index == 8'h00;
	// flags follow the index one clock later
	a_last_flag: assert property (1 |=> last_frame_flag == $past(frame_index == 8'hBF))
		else $error("last frame flag wrong");
	a_win_flag: assert property (1 |=> crc_out_en == $past(in_win))
		else $error("window flag wrong");
	a_start_flag: assert property (1 |=> block_start_flag == $past(aresetn && frame_index == 8'h00))
		else $error("block start flag wrong");
	a_pass_thru: assert property (word_ce && !in_win |=> status_out == $past(status_in))
		else $error("bit not passed through");
	a_out_hold: assert property (!word_ce |=> $stable(status_out))
		else $error("output moved without enable");
	a_err_set: assert property (word_ce && in_win |=> status_out == $past(status_in) || crc_err)
		else $error("mismatch not flagged");
	a_err_cause: assert property ($rose(crc_err) |-> $past(word_ce && in_win))
		else $error("mismatch flag outside window");
	a_err_clear: assert property (at_start |=> !crc_err)
		else $error("mismatch not cleared");
	a_err_hold: assert property (crc_err && !at_start |=> crc_err)
		else $error("mismatch not held");
	// main scenarios
	c_last: cover property (word_ce && frame_index == 8'hBF);
	c_err: cover property ($rose(crc_err));
	c_clear: cover property (crc_err && at_start);
endmodule

// ===== bench/csc_crc_top_bench.sv
// self-checking bench of the crc unit: registers, stream blocks, mismatch, irq.
// assumes the design files and the framing model compile ahead of it.
`timescale 1ns/1ps
module csc_crc_top_bench import csc_pkg::*; ();
	logic aclk = 1'h0, aresetn = 1'h0, run = 1'h0, bad = 1'h0;
	logic word_ce, status_in, status_out, crc_out_en, lff, bsf, crc_err, irq, blk_start;
	logic awready, wready, bvalid, arready, rvalid;
	logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
	logic [7:0] frame_index, exp_crc, awaddr = 8'h00, araddr = 8'h00, src_crc = 8'h00;
	logic [31:0] wdata = 32'h0, rdata;
	logic [1:0] bresp, rresp;
	int failures = 0, checks = 0;
	always #4 aclk = ~aclk;
	// one unit for this single status stream
	csc_crc_top i_csc_crc_top (.aclk(aclk), .aresetn(aresetn), .word_ce(word_ce),
		.frame_index(frame_index), .status_in(status_in), .status_out(status_out),
		.crc_out_en(crc_out_en), .last_frame_flag(lff), .block_start_flag(bsf),
		.crc_err(crc_err), .irq(irq), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready));
	csc_frame_src i_csc_frame_src (.aclk(aclk), .aresetn(aresetn), .run(run), .bad(bad),
		.crc_byte(src_crc), .last_frame_flag(lff), .word_ce(word_ce),
		.frame_index(frame_index), .status_in(status_in), .blk_start(blk_start));
	// reference check byte over the model's bit pattern
	function automatic logic [7:0] calc_crc();
		logic [7:0] c;
		logic [7:0] i;
		c = 8'hFF;
		for (int k = 0; k < 184; k++) begin
			i = 8'(k);
			c = {c[6:0], 1'h0} ^ ((c[7] ^ i[0] ^ i[2] ^ i[5]) ? 8'h1D : 8'h00);
		end
		return c;
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			failures++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic aw_ok, w_ok;
		aw_ok = 1'h0;
		w_ok = 1'h0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		while (!(aw_ok && w_ok)) begin
			@(posedge aclk);
			if (awvalid && awready) begin
				aw_ok = 1'h1;
				awvalid <= 1'h0;
			end
			if (wvalid && wready) begin
				w_ok = 1'h1;
				wvalid <= 1'h0;
			end
		end
		do @(posedge aclk); while (!bvalid);
		r = bresp;
		bready <= 1'h0;
	endtask
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		do @(posedge aclk); while (!arready);
		arvalid <= 1'h0;
		do @(posedge aclk); while (!rvalid);
		d = rdata;
		r = rresp;
		rready <= 1'h0;
	endtask
	// one block from frame 0, output bit judged after each enable
	task automatic run_block(input logic ins, input logic bd, input logic [7:0] sent);
		logic [7:0] i;
		logic x;
		@(posedge aclk);
		bad <= bd;
		src_crc <= sent;
		run <= 1'h1;
		do @(negedge aclk); while (!(word_ce && frame_index == 8'h00));
		for (int k = 0; k < 192; k++) begin
			if (k > 0)
				do @(negedge aclk); while (!word_ce);
			i = frame_index;
			x = status_in;
			chk(32'({lff, crc_out_en, bsf, blk_start}), 32'({k == 191, k >= 184, k == 0, k == 0}));
			@(negedge aclk);
			chk(32'(status_out), 32'((i >= 8'hB8 && ins) ? exp_crc[8'hBF - i] : x));
		end
		chk(32'(crc_err), 32'(bd || sent != exp_crc));
		@(posedge aclk);
		run <= 1'h0;
	endtask
	task automatic t_regs();
		logic [31:0] d;
		logic [1:0] r;
		axi_rd(8'h00, d, r);
		chk(d, 32'h3);
		axi_rd(8'h04, d, r);
		chk(d, 32'hFF);
		axi_rd(8'h10, d, r);
		chk(d, 32'h0);
		axi_rd(8'h3C, d, r);
		chk(32'(r), 32'(CSC_RESP_SLVERR));
		axi_wr(8'h3C, 32'h1, r);
		chk(32'(r), 32'(CSC_RESP_SLVERR));
	endtask
	// two good blocks back to back: preset per block
	task automatic t_good();
		run_block(1'h1, 1'h0, exp_crc);
		run_block(1'h1, 1'h0, exp_crc);
	endtask
	// spoilt byte 23 with insertion off, then irq mask and clear
	task automatic t_bad();
		logic [31:0] d;
		logic [1:0] r;
		axi_wr(8'h00, 32'h1, r);
		run_block(1'h0, 1'h1, exp_crc);
		axi_rd(8'h14, d, r);
		chk(d, {24'h0, exp_crc});
		axi_rd(8'h0C, d, r);
		chk(d, 32'h3);
		chk(32'(irq), 32'h0);
		axi_wr(8'h10, 32'h2, r);
		repeat (2) @(negedge aclk);
		chk(32'(irq), 32'h1);
		axi_wr(8'h0C, 32'h3, r);
		repeat (2) @(negedge aclk);
		chk(32'(irq), 32'h0);
		chk(32'(crc_err), 32'h1);
		@(posedge aclk);
		run <= 1'h1;
		do @(negedge aclk); while (!word_ce);
		@(negedge aclk);
		chk(32'(crc_err), 32'h0);
	endtask
	// source without a check byte sends zeros; unit still inserts its own
	task automatic t_zero();
		logic [1:0] r;
		axi_wr(8'h00, 32'h3, r);
		run_block(1'h1, 1'h0, 8'h00);
	endtask
	task automatic print_verdict();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		exp_crc = calc_crc();
		repeat (10) @(posedge aclk);
		aresetn <= 1'h1;
		t_regs();
		t_good();
		t_bad();
		t_zero();
		print_verdict();
	end
	// watchdog far beyond the four blocks of traffic
	initial begin
		#200000;
		failures++;
		print_verdict();
	end
endmodule
bind csc_crc_top csc_crc_checker i_csc_crc_checker (.aclk(aclk), .aresetn(aresetn),
	.word_ce(word_ce), .frame_index(frame_index), .status_in(status_in),
	.status_out(status_out), .crc_out_en(crc_out_en), .last_frame_flag(last_frame_flag),
	.block_start_flag(block_start_flag), .crc_err(crc_err));

// ===== bench/csc_frame_src.sv
// framing source model: frame enable, frame counter and serial status bits.
// assumes the bench hands it the check byte sent in byte 23.
`timescale 1ns/1ps
module csc_frame_src (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic run,
	input wire logic bad,
	input wire logic [7:0] crc_byte,
	input wire logic last_frame_flag,
	output logic word_ce,
	output logic [7:0] frame_index,
	output logic status_in,
	output logic blk_start
);
	logic [1:0] cnt_q;
	logic start_q;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_q <= 2'h0;
			word_ce <= 1'h0;
		end else begin
			cnt_q <= cnt_q + 2'h1;
			word_ce <= run && cnt_q == 2'h3;
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn)
			frame_index <= 8'h00;
		else if (word_ce)
			frame_index <= last_frame_flag ? 8'h00 : frame_index + 8'h01;
	end
	// block start is the last-frame flag one frame late
	always_ff @(posedge aclk) begin
		if (!aresetn)
			start_q <= 1'h1;
		else if (word_ce)
			start_q <= last_frame_flag;
	end
	assign blk_start = start_q;
	// check byte msb first, one bit spoilt on demand
	assign status_in = frame_index >= 8'hB8 ?
		crc_byte[8'hBF - frame_index] ^ (bad && frame_index == 8'hBA) :
		frame_index[0] ^ frame_index[2] ^ frame_index[5];
endmodule

// ===== rtl/csc_consts.svh
// constants of the channel status crc unit: frame numbers, polynomial,
// register offsets, field positions and reset values.
// assumes inclusion by bare name from the design files.
`ifndef CSC_CONSTS_SVH
`define CSC_CONSTS_SVH

// frame numbers within a 192-frame block
`define CSC_FRAME_FIRST 8'h00
`define CSC_FRAME_WIN_LO 8'hB8
`define CSC_FRAME_WIN_HI 8'hBF
`define CSC_FRAME_LAST 8'hBF

// generator x^8 + x^4 + x^3 + x^2 + 1, top term implied
`define CSC_POLY 8'h1D
`define CSC_CRC_W 8

// register byte offsets
`define CSC_OFF_CTRL 8'h00
`define CSC_OFF_INIT 8'h04
`define CSC_OFF_STATUS 8'h08
`define CSC_OFF_IRQ_STAT 8'h0C
`define CSC_OFF_IRQ_MASK 8'h10
`define CSC_OFF_LAST_CRC 8'h14

// control fields
`define CSC_CTRL_CHECK_BIT 0
`define CSC_CTRL_INSERT_BIT 1
`define CSC_CTRL_RST 2'h3

// preset of the check register
`define CSC_INIT_RST 8'hFF

// interrupt fields
`define CSC_IRQ_W 2
`define CSC_IRQ_DONE_BIT 0
`define CSC_IRQ_ERR_BIT 1
`define CSC_IRQ_MASK_RST 2'h0

`endif

// ===== rtl/csc_crc_step.sv
// one serial step of a crc shift register, msb-first feedback.
// assumes the caller registers the result.
`timescale 1ns/1ps
`include "csc_consts.svh"

module csc_crc_step #(
	parameter int WIDTH = `CSC_CRC_W,
	parameter logic [WIDTH-1:0] POLY = `CSC_POLY
) (
	input wire logic [WIDTH-1:0] state,
	input wire logic bit_in,
	output logic [WIDTH-1:0] state_next
);

	// feedback from the outgoing top bit and the new data bit
	wire fb = state[WIDTH-1] ^ bit_in;
	assign state_next = {state[WIDTH-2:0], 1'b0} ^ (fb ? POLY : {WIDTH{1'b0}});

endmodule

// ===== rtl/csc_crc_top.sv
// channel status crc generator and checker with an axi4-lite register slave.
// assumes word_ce, frame_index and status_in come from logic on aclk, one
// word_ce pulse per audio frame and frame_index steady around it.
`timescale 1ns/1ps
`include "csc_consts.svh"

module csc_crc_top import csc_pkg::*; #(
	parameter int ADDR_W = 8
) (
	input wire logic aclk,
	input wire logic aresetn,
	// stream side
	input wire logic word_ce,
	input wire logic [7:0] frame_index,
	input wire logic status_in,
	output logic status_out,
	output logic crc_out_en,
	output logic last_frame_flag,
	output logic block_start_flag,
	output logic crc_err,
	output logic irq,
	// axi4-lite slave
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);

	// ---------------- register state ----------------
	logic [1:0] ctrl_q;
	csc_byte_t init_q;
	logic [`CSC_IRQ_W-1:0] irq_stat_q;
	logic [`CSC_IRQ_W-1:0] irq_mask_q;
	logic [`CSC_IRQ_W-1:0] irq_stat_d;

	// ---------------- crc datapath state ----------------
	csc_byte_t crc_q;
	csc_byte_t crc_d;
	csc_byte_t crc_step_out;
	csc_byte_t last_crc_q;
	csc_byte_t rx_byte_q;
	logic rx_last_err_q;
	logic dout_q;
	logic win_q;
	logic last_q;
	logic first_q;
	logic err_q;
	logic irq_q;

	// frame decode
	wire at_first = (frame_index == `CSC_FRAME_FIRST);
	wire at_last = (frame_index == `CSC_FRAME_LAST);
	wire in_win = (frame_index >= `CSC_FRAME_WIN_LO) && (frame_index <= `CSC_FRAME_WIN_HI);
	wire check_en = ctrl_q[`CSC_CTRL_CHECK_BIT];
	wire insert_en = ctrl_q[`CSC_CTRL_INSERT_BIT];

	wire csc_byte_t seed = at_first ? init_q : crc_q;

	csc_crc_step #(
		.WIDTH(`CSC_CRC_W),
		.POLY(`CSC_POLY)
	) u_step (
		.state(seed),
		.bit_in(status_in),
		.state_next(crc_step_out)
	);

	// accumulate over bytes 0-22, then shift result out in byte 23
	assign crc_d = in_win ? {crc_q[6:0], 1'b0} : crc_step_out;

	// compare incoming bit with outgoing check bit
	wire mismatch = word_ce && in_win && check_en && (status_in != crc_q[7]);

	// events for the interrupt status
	wire ev_done = word_ce && at_last;
	wire ev_err = mismatch;

	// check register advances only on word_ce
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			crc_q <= `CSC_INIT_RST;
		end else if (word_ce) begin
			crc_q <= crc_d;
		end
	end

	// pass input through outside the check window
	// insert check bits during byte 23
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			dout_q <= 1'b0;
		end else if (word_ce) begin
			dout_q <= (in_win && insert_en) ? crc_q[7] : status_in;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			win_q <= 1'b0;
			last_q <= 1'b0;
			first_q <= 1'b0;
		end else begin
			win_q <= in_win;
			last_q <= at_last;
			first_q <= at_first;
		end
	end

	// mismatch held until frame 0, set beats clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			err_q <= 1'b0;
		end else if (mismatch) begin
			err_q <= 1'b1;
		end else if (word_ce && at_first) begin
			err_q <= 1'b0;
		end
	end

	// capture computed and received byte 23 for software
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			last_crc_q <= 8'h00;
			rx_byte_q <= 8'h00;
			rx_last_err_q <= 1'b0;
		end else if (word_ce) begin
			if (frame_index == `CSC_FRAME_WIN_LO) begin
				last_crc_q <= crc_q;
			end
			if (in_win) begin
				rx_byte_q <= {rx_byte_q[6:0], status_in};
			end
			if (at_last) begin
				rx_last_err_q <= err_q | mismatch;
			end
		end
	end

	// ---------------- axi4-lite write channel ----------------
	logic awready_q;
	logic wready_q;
	logic aw_got_q;
	logic w_got_q;
	logic [ADDR_W-1:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic bvalid_q;
	logic [1:0] bresp_q;

	wire aw_take = s_axi_awvalid && awready_q;
	wire w_take = s_axi_wvalid && wready_q;
	wire do_write = aw_got_q && w_got_q && !bvalid_q;
	wire bvalid_d = do_write || (bvalid_q && !s_axi_bready);
	wire aw_got_d = (aw_got_q || aw_take) && !do_write;
	wire w_got_d = (w_got_q || w_take) && !do_write;
	wire [7:0] wr_off = 8'({awaddr_q[ADDR_W-1:2], 2'b00});

	// write decode
	wire wr_ctrl = do_write && (wr_off == `CSC_OFF_CTRL) && wstrb_q[0];
	wire wr_init = do_write && (wr_off == `CSC_OFF_INIT) && wstrb_q[0];
	wire wr_istat = do_write && (wr_off == `CSC_OFF_IRQ_STAT) && wstrb_q[0];
	wire wr_imask = do_write && (wr_off == `CSC_OFF_IRQ_MASK) && wstrb_q[0];
	wire wr_hit = (wr_off == `CSC_OFF_CTRL) || (wr_off == `CSC_OFF_INIT) ||
		(wr_off == `CSC_OFF_STATUS) || (wr_off == `CSC_OFF_IRQ_STAT) ||
		(wr_off == `CSC_OFF_IRQ_MASK) || (wr_off == `CSC_OFF_LAST_CRC);

	// address and data latches, taken in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_q <= 1'b0;
			w_got_q <= 1'b0;
			awaddr_q <= '0;
			wdata_q <= 32'h00000000;
			wstrb_q <= 4'h0;
		end else begin
			aw_got_q <= aw_got_d;
			w_got_q <= w_got_d;
			if (aw_take) begin
				awaddr_q <= s_axi_awaddr;
			end
			if (w_take) begin
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
		end
	end

	// ready flags and write response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_q <= 1'b0;
			wready_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q <= CSC_RESP_OKAY;
		end else begin
			awready_q <= !aw_got_d && !bvalid_d;
			wready_q <= !w_got_d && !bvalid_d;
			bvalid_q <= bvalid_d;
			if (do_write) begin
				bresp_q <= wr_hit ? CSC_RESP_OKAY : CSC_RESP_SLVERR;
			end
		end
	end

	// software registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_q <= `CSC_CTRL_RST;
			init_q <= `CSC_INIT_RST;
			irq_mask_q <= `CSC_IRQ_MASK_RST;
		end else begin
			if (wr_ctrl) begin
				ctrl_q <= wdata_q[1:0];
			end
			if (wr_init) begin
				init_q <= wdata_q[7:0];
			end
			if (wr_imask) begin
				irq_mask_q <= wdata_q[`CSC_IRQ_W-1:0];
			end
		end
	end

	// sticky events, write one to clear, new event wins
	wire [`CSC_IRQ_W-1:0] istat_clr = wr_istat ? wdata_q[`CSC_IRQ_W-1:0] : '0;
	wire [`CSC_IRQ_W-1:0] istat_set = {ev_err, ev_done};
	assign irq_stat_d = (irq_stat_q & ~istat_clr) | istat_set;

	// interrupt status and level output
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_stat_q <= '0;
			irq_q <= 1'b0;
		end else begin
			irq_stat_q <= irq_stat_d;
			irq_q <= |(irq_stat_q & irq_mask_q);
		end
	end

	// ---------------- axi4-lite read channel ----------------
	logic arready_q;
	logic rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0] rresp_q;

	wire ar_take = s_axi_arvalid && arready_q;
	wire rvalid_d = ar_take || (rvalid_q && !s_axi_rready);
	wire [7:0] rd_off = 8'({s_axi_araddr[ADDR_W-1:2], 2'b00});

	// read decode; status shows error, window, last flag and index
	wire [31:0] rd_status = {8'h00, rx_byte_q, frame_index, 4'h0,
		rx_last_err_q, win_q, last_q, err_q};
	wire [31:0] rd_data =
		(rd_off == `CSC_OFF_CTRL) ? {30'h0, ctrl_q} :
		(rd_off == `CSC_OFF_INIT) ? {24'h0, init_q} :
		(rd_off == `CSC_OFF_STATUS) ? rd_status :
		(rd_off == `CSC_OFF_IRQ_STAT) ? {30'h0, irq_stat_q} :
		(rd_off == `CSC_OFF_IRQ_MASK) ? {30'h0, irq_mask_q} :
		(rd_off == `CSC_OFF_LAST_CRC) ? {24'h0, last_crc_q} :
		32'h00000000;
	wire rd_hit = (rd_off == `CSC_OFF_CTRL) || (rd_off == `CSC_OFF_INIT) ||
		(rd_off == `CSC_OFF_STATUS) || (rd_off == `CSC_OFF_IRQ_STAT) ||
		(rd_off == `CSC_OFF_IRQ_MASK) || (rd_off == `CSC_OFF_LAST_CRC);

	// read address accept and data return
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_q <= 1'b0;
			rvalid_q <= 1'b0;
			rdata_q <= 32'h00000000;
			rresp_q <= CSC_RESP_OKAY;
		end else begin
			arready_q <= !rvalid_d;
			rvalid_q <= rvalid_d;
			if (ar_take) begin
				rdata_q <= rd_data;
				rresp_q <= rd_hit ? CSC_RESP_OKAY : CSC_RESP_SLVERR;
			end
		end
	end

	// ---------------- outputs ----------------
	assign status_out = dout_q;
	assign crc_out_en = win_q;
	assign last_frame_flag = last_q;
	// block start marks frame 0 for a transmitter
	assign block_start_flag = first_q;
	assign crc_err = err_q;
	assign irq = irq_q;
	assign s_axi_awready = awready_q;
	assign s_axi_wready = wready_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_arready = arready_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;

	// protection bits carry no meaning here
	wire unused_prot = ^{s_axi_awprot, s_axi_arprot, wdata_q[31:8], wstrb_q[3:1]};

endmodule

// ===== rtl/csc_pkg.sv
// types shared by the channel status crc unit.
// assumes nothing of its surroundings.
package csc_pkg;

	typedef logic [7:0] csc_byte_t;

	typedef enum logic [1:0] {
		CSC_RESP_OKAY = 2'h0,
		CSC_RESP_SLVERR = 2'h2
	} csc_resp_t;

endpackage
